// File: design/pipelined_adc_output_control.sv
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "adc_out_regs.svh"

// Notes on behaviour
// [RL1] each result appears on the outputs seven clock edges after sampling
// [RL2] output word changes only right after a rising clock edge
// [RL3] standby request high shuts down reference, buffer and bias
// [RL4] in standby all data output drivers are released
// [RL5] standby request low returns to normal conversion
// [RL6] after long standby wait about 5 ms before trusting results
// [RL7] enabled stabilizer regenerates falling edge for 50% internal duty
// [RL8] after clock rate change discard about 100 cycles while loop relocks
// [RL9] sample clock should run at 1 MSPS or faster
// [RL10] each sample is a 12-bit parallel word updated together
// [RL11] output format selects offset binary or two's complement
// [RL12] gated or divided sample clock should be retimed by its source
// [RL13] input sampled on rising clock edge, new conversion every cycle
// [RL14] four-level mode pin picks format and stabilizer state
// [RL15] first seven words after standby or clock start are invalid
// [RL16] capture logic ignores the data bus while standby is requested
module pipelined_adc_output_control #(
	parameter int WIDTH = `SAMPLE_BITS,
	parameter int LATENCY = `PIPE_LATENCY,
	parameter int FIFO_DEPTH = `FIFO_DEPTH,
	parameter int WAKE_CYCLES = `WAKE_CYCLES,
	parameter int DISCHARGE_RATIO = `DISCHARGE_RATIO,
	parameter int LOCK_CYCLES = `LOCK_CYCLES
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// apb register port
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// quantised result from the converter core
	input wire logic [WIDTH-1:0] sample_code,
	// control pins
	input wire logic standby_request,
	input wire logic [1:0] mode_level,
	// data output pins
	output logic [WIDTH-1:0] data_out,
	output logic data_oe,
	output logic data_valid,
	// analog and clock control
	output logic reference_enable,
	output logic bias_enable,
	output logic duty_cycle_stabilizer,
	output logic dcs_locked,
	output logic wake_ready
);

	localparam int CW = $clog2(WAKE_CYCLES + 1);
	localparam int DW = $clog2(DISCHARGE_RATIO + 1);
	localparam int LW = $clog2(LOCK_CYCLES + 1);

	// ==========================================================
	// mode decode
	function automatic adc_out_pkg::mode_cfg_t decode_mode(input adc_out_pkg::mode_level_t lvl);
		adc_out_pkg::mode_cfg_t cfg;
		cfg = '0;
		case (lvl)
			2'h3: cfg = '{twos_comp: 1'b1, dcs_on: 1'b0}; // full supply
			2'h2: cfg = '{twos_comp: 1'b1, dcs_on: 1'b1}; // two thirds supply
			2'h1: cfg = '{twos_comp: 1'b0, dcs_on: 1'b1}; // one third supply
			default: cfg = '{twos_comp: 1'b0, dcs_on: 1'b0}; // ground, pulled down
		endcase
		return cfg;
	endfunction

	// ==========================================================
	// pin synchronisers
	logic [1:0] standby_meta_q;
	logic [1:0] standby_sync_q;
	logic [1:0] mode_meta_q;
	logic [1:0] mode_sync_q;

	// the mode pin is a strap, so a two-bit sync is safe in practice
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			standby_meta_q <= 2'h0;
			mode_meta_q <= 2'h0;
			mode_sync_q <= 2'h0;
		end else begin
			standby_meta_q <= {standby_meta_q[0], standby_request};
			mode_meta_q <= mode_level;
			mode_sync_q <= mode_meta_q;
		end
	end
	assign standby_sync_q = standby_meta_q;

	// ==========================================================
	// register state
	logic [31:0] ctrl_q;
	logic overflow_q;
	logic [31:0] prdata_q;
	logic rd_pending_q;
	logic setup;
	logic access;
	logic wr_ctrl;
	logic wr_status;
	logic mapped;
	adc_out_pkg::mode_cfg_t mode_cfg;
	logic standby;

	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign mapped = (paddr == `REG_CTRL) | (paddr == `REG_STATUS) | (paddr == `REG_CAPTURE);
	assign wr_ctrl = access & pwrite & (paddr == `REG_CTRL);
	assign wr_status = access & pwrite & (paddr == `REG_STATUS);

	// software may override the strap, else the pin decides
	assign mode_cfg = ctrl_q[`CTRL_MODE_OVR] ? // RL14
		decode_mode(ctrl_q[`CTRL_MODE_HI:`CTRL_MODE_LO]) : decode_mode(mode_sync_q);

	// pin or software may request standby
	assign standby = standby_sync_q[1] | ctrl_q[`CTRL_SOFT_STANDBY]; // RL3 RL5

	// ==========================================================
	// power state: standby drops reference and bias
	adc_out_pkg::pwr_state_t pwr_q;
	adc_out_pkg::pwr_state_t pwr_d;

	always_comb begin
		pwr_d = pwr_q;
		case (pwr_q)
			adc_out_pkg::PWR_ACTIVE: if (standby) pwr_d = adc_out_pkg::PWR_STANDBY; // RL3
			adc_out_pkg::PWR_STANDBY: if (!standby) pwr_d = adc_out_pkg::PWR_ACTIVE; // RL5
			default: pwr_d = adc_out_pkg::PWR_ACTIVE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			pwr_q <= adc_out_pkg::PWR_ACTIVE;
		end else begin
			pwr_q <= pwr_d;
		end
	end

	logic in_standby;
	assign in_standby = (pwr_q == adc_out_pkg::PWR_STANDBY);
	assign reference_enable = ~in_standby; // RL3
	assign bias_enable = ~in_standby; // RL3

	// ==========================================================
	// reference charge model: drains slowly in standby, refills at
	// one step per cycle, so short standby gives a short wake-up
	logic [CW-1:0] charge_q;
	logic [DW-1:0] drain_div_q;

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			charge_q <= '0;
			drain_div_q <= '0;
		end else if (in_standby) begin
			if (drain_div_q == DW'(DISCHARGE_RATIO - 1)) begin
				drain_div_q <= '0;
				if (charge_q != '0) charge_q <= charge_q - 1'b1; // RL6
			end else begin
				drain_div_q <= drain_div_q + 1'b1;
			end
		end else begin
			drain_div_q <= '0;
			if (charge_q != CW'(WAKE_CYCLES)) charge_q <= charge_q + 1'b1; // RL6
		end
	end
	assign wake_ready = ~in_standby & (charge_q == CW'(WAKE_CYCLES));

	// ==========================================================
	// duty-cycle stabilizer loop: lock count restarts on enable, on
	// wake, or when software reports a new clock rate
	logic [LW-1:0] lock_cnt_q;
	logic dcs_on_q;
	logic relock;

	assign relock = (wr_ctrl & pwdata[`CTRL_RELOCK]) | in_standby | (mode_cfg.dcs_on != dcs_on_q);

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			lock_cnt_q <= '0;
			dcs_on_q <= 1'b0;
		end else begin
			dcs_on_q <= mode_cfg.dcs_on;
			if (relock) begin
				lock_cnt_q <= '0; // RL8
			end else if (lock_cnt_q != LW'(LOCK_CYCLES)) begin
				lock_cnt_q <= lock_cnt_q + 1'b1; // RL8
			end
		end
	end
	// enable drives the edge regenerator in the clock front end
	assign duty_cycle_stabilizer = dcs_on_q & ~in_standby; // RL7
	assign dcs_locked = ~dcs_on_q | (lock_cnt_q == LW'(LOCK_CYCLES)); // RL7

	// ==========================================================
	// conversion pipeline: a new sample every rising edge
	logic [WIDTH-1:0] stage_q [LATENCY];
	logic [LATENCY-1:0] stage_vld_q;

	always_ff @(posedge clock) begin
		if (!rst_b || in_standby) begin
			stage_vld_q[0] <= 1'b0; // RL15
		end else begin
			stage_vld_q[0] <= 1'b1;
		end
		stage_q[0] <= sample_code; // RL13
	end

	genvar g;
	generate
		for (g = 1; g < LATENCY; g++) begin : g_stage
			// standby flushes validity so the refill is visible
			always_ff @(posedge clock) begin
				if (!rst_b || in_standby) begin
					stage_vld_q[g] <= 1'b0; // RL15
				end else begin
					stage_vld_q[g] <= stage_vld_q[g-1];
				end
				stage_q[g] <= stage_q[g-1];
			end
		end
	endgenerate

	// ==========================================================
	// output latch: whole word updates on one edge, format applied here
	logic [WIDTH-1:0] out_q;
	logic out_vld_q;
	logic oe_q;

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			out_q <= '0;
			out_vld_q <= 1'b0;
			oe_q <= 1'b0;
		end else begin
			// twos complement is offset binary with the msb flipped
			out_q <= {stage_q[LATENCY-1][WIDTH-1] ^ mode_cfg.twos_comp, // RL11
				stage_q[LATENCY-1][WIDTH-2:0]}; // RL1 RL2 RL10
			out_vld_q <= stage_vld_q[LATENCY-1] & ~in_standby & wake_ready; // RL15
			oe_q <= ~in_standby; // RL4
		end
	end
	assign data_out = out_q;
	assign data_oe = oe_q & ~in_standby; // RL4 RL16
	assign data_valid = out_vld_q & ~in_standby & dcs_locked;

	// ==========================================================
	// capture buffer: valid output words go to the fifo for software
	sample_stream_if #(.WIDTH(WIDTH)) fill_if ();
	sample_stream_if #(.WIDTH(WIDTH)) drain_if ();

	sample_fifo #(.WIDTH(WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clock(clock),
		.rst_b(rst_b),
		.push(fill_if),
		.pop(drain_if)
	);

	// capture stalls while the fifo is full; lost words flag overflow
	assign fill_if.valid = data_valid & ctrl_q[`CTRL_CAPTURE_EN];
	assign fill_if.data = out_q;
	assign drain_if.ready = access & ~pwrite & (paddr == `REG_CAPTURE) & rd_pending_q;

	// ==========================================================
	// control register and overflow flag
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			ctrl_q <= `CTRL_RESET;
		end else if (wr_ctrl) begin
			// relock bit is a strobe and is not stored
			ctrl_q <= {26'h0, pwdata[`CTRL_SOFT_STANDBY],
				1'b0, pwdata[`CTRL_CAPTURE_EN:`CTRL_MODE_OVR]};
		end
	end

	// a word lost in the clearing cycle still sets the flag
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			overflow_q <= 1'b0;
		end else if (fill_if.valid && !fill_if.ready) begin
			overflow_q <= 1'b1;
		end else if (wr_status && pwdata[`STAT_OVERFLOW]) begin
			overflow_q <= 1'b0;
		end
	end

	// ==========================================================
	// read data is latched in the setup phase; the fifo head only
	// moves on a capture pop, so the snapshot stays correct
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			prdata_q <= 32'h0000_0000;
			rd_pending_q <= 1'b0;
		end else if (setup && !pwrite) begin
			prdata_q <= 32'h0000_0000;
			rd_pending_q <= 1'b0;
			case (paddr)
				`REG_CTRL: prdata_q <= ctrl_q;
				`REG_STATUS: begin
					prdata_q[`STAT_STANDBY] <= in_standby;
					prdata_q[`STAT_TWOS_COMP] <= mode_cfg.twos_comp;
					prdata_q[`STAT_DCS_ON] <= dcs_on_q;
					prdata_q[`STAT_DCS_LOCKED] <= dcs_locked;
					prdata_q[`STAT_WAKE_READY] <= wake_ready;
					prdata_q[`STAT_OVERFLOW] <= overflow_q;
					prdata_q[`STAT_FIFO_EMPTY] <= ~drain_if.valid;
					prdata_q[`STAT_FIFO_FULL] <= ~fill_if.ready;
				end
				`REG_CAPTURE: begin
					prdata_q[`CAPT_VALID] <= drain_if.valid;
					prdata_q[WIDTH-1:0] <= drain_if.data;
					rd_pending_q <= drain_if.valid;
				end
				default: prdata_q <= 32'h0000_0000;
			endcase
		end else if (access) begin
			rd_pending_q <= 1'b0;
		end
	end

	// zero wait states; unmapped addresses answer with an error
	assign prdata = prdata_q;
	assign pready = 1'b1;
	assign pslverr = access & ~mapped;

endmodule // pipelined_adc_output_control

// File: design/sample_fifo.sv
`timescale 1ns/1ps

// ==========================================================
// synchronous word fifo, depth must be a power of two
module sample_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// filling side
	sample_stream_if.snk push,
	// draining side
	sample_stream_if.src pop
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] count_q;
	logic do_push;
	logic do_pop;

	// handshakes; full and empty come straight from the count
	assign push.ready = (count_q != (AW+1)'(DEPTH));
	assign pop.valid = (count_q != '0);
	assign pop.data = mem[rd_q];
	assign do_push = push.valid & push.ready;
	assign do_pop = pop.valid & pop.ready;

	// storage has no reset, only the pointers and the fill count need one
	always_ff @(posedge clock) begin
		if (do_push) begin
			mem[wr_q] <= push.data;
		end
	end

	// pointers and fill count
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			wr_q <= '0;
			rd_q <= '0;
			count_q <= '0;
		end else begin
			if (do_push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (do_pop) begin
				rd_q <= rd_q + 1'b1;
			end
			if (do_push && !do_pop) begin
				count_q <= count_q + 1'b1;
			end else if (do_pop && !do_push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end

endmodule // sample_fifo

// File: shared/adc_out_pkg.sv
package adc_out_pkg;

	// ==========================================================
	// level code of the four-level mode pin after the comparators
	typedef logic [1:0] mode_level_t;

	// decoded mode: output format and stabilizer state
	typedef struct packed {
		logic twos_comp;
		logic dcs_on;
	} mode_cfg_t;

	// power state of the converter
	typedef enum logic [1:0] {
		PWR_ACTIVE,
		PWR_STANDBY
	} pwr_state_t;

endpackage

// File: shared/adc_out_regs.svh
`ifndef ADC_OUT_REGS_SVH
`define ADC_OUT_REGS_SVH

// ==========================================================
// register map (byte addresses on the apb bus)
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_CAPTURE 8'h08

// ==========================================================
// control register fields
`define CTRL_MODE_OVR 0
`define CTRL_MODE_LO 1
`define CTRL_MODE_HI 2
`define CTRL_CAPTURE_EN 3
`define CTRL_RELOCK 4
`define CTRL_SOFT_STANDBY 5
`define CTRL_RESET 32'h0000_0000

// ==========================================================
// status register fields
`define STAT_STANDBY 0
`define STAT_TWOS_COMP 1
`define STAT_DCS_ON 2
`define STAT_DCS_LOCKED 3
`define STAT_WAKE_READY 4
`define STAT_OVERFLOW 5
`define STAT_FIFO_EMPTY 6
`define STAT_FIFO_FULL 7

// ==========================================================
// capture register fields
`define CAPT_VALID 16

// ==========================================================
// timing and sizes
`define SAMPLE_BITS 12
`define PIPE_LATENCY 7
`define FIFO_DEPTH 8
`define CLK_MHZ 20
`define WAKE_TIME_US 5000
`define DISCHARGE_TIME_US 1000000
`define WAKE_CYCLES (`WAKE_TIME_US * `CLK_MHZ)
`define DISCHARGE_RATIO (`DISCHARGE_TIME_US / `WAKE_TIME_US)
`define LOCK_CYCLES 100

`endif

// File: shared/sample_stream_if.sv
`timescale 1ns/1ps

// ==========================================================
// valid/ready word stream between the converter and its buffer
interface sample_stream_if #(parameter int WIDTH = 12);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface

// File: testbench/adc_out_asserts.sv
`timescale 1ns/1ps

// ==========================================================
// port checks of the converter output block
module adc_out_asserts #(
	parameter int WIDTH = 12,
	parameter int LOCK_CYCLES = 100
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	// stream and pins
	input wire logic [WIDTH-1:0] sample_code,
	input wire logic standby_request,
	input wire logic [1:0] mode_level,
	input wire logic [WIDTH-1:0] data_out,
	input wire logic data_oe,
	input wire logic data_valid,
	input wire logic reference_enable,
	input wire logic bias_enable,
	input wire logic duty_cycle_stabilizer,
	input wire logic dcs_locked,
	input wire logic wake_ready
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);
	logic [15:0] lock_cnt_q;
	// cycles spent unlocked with the loop on; clears when off or locked
	always_ff @(posedge clock) begin
		if (!rst_b || !duty_cycle_stabilizer || dcs_locked) lock_cnt_q <= 16'h0000;
		else lock_cnt_q <= lock_cnt_q + 16'h0001;
	end
	// six samples cover the pin synchroniser and the state register
	sequence s_asleep;
		standby_request [*6];
	endsequence
	sequence s_awake;
		!standby_request [*6];
	endsequence
	a_pipe_latency: assert property (data_valid && mode_level == $past(mode_level, 12)
		|-> data_out == {sample_code[WIDTH-1] ^ 1'b0, {(WIDTH-1){1'b0}}} ^
		{$past(sample_code[WIDTH-1], 8) ^ sample_code[WIDTH-1] ^ mode_level[1],
		$past(sample_code[WIDTH-2:0], 8)}) else $error("output word not seven samples late");
	a_standby_float: assert property (s_asleep |-> !data_oe && !data_valid)
		else $error("outputs driven in standby");
	a_refs_off: assert property (s_asleep |-> !reference_enable && !bias_enable)
		else $error("reference or bias on in standby");
	a_sleep_wake: assert property (s_asleep |-> !wake_ready && !duty_cycle_stabilizer)
		else $error("wake or stabilizer high in standby");
	a_refill_gap: assert property ($rose(data_oe) |-> !data_valid [*7])
		else $error("valid before pipeline refill");
	a_valid_gate: assert property (data_valid |-> data_oe && wake_ready && dcs_locked)
		else $error("valid while not ready");
	a_dcs_mode: assert property (s_awake ##0 mode_level == $past(mode_level, 6)
		|-> duty_cycle_stabilizer == (mode_level inside {2'h1, 2'h2}))
		else $error("stabilizer state does not follow mode");
	a_lock_time: assert property ($rose(dcs_locked) && duty_cycle_stabilizer
		|-> lock_cnt_q + 3 >= LOCK_CYCLES && lock_cnt_q <= LOCK_CYCLES + 3)
		else $error("lock count off");
	a_lock_bound: assert property (lock_cnt_q <= LOCK_CYCLES + 3)
		else $error("loop never locks");
	a_unmapped_err: assert property (psel && penable
		|-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08}) && (!pslverr || pwrite || prdata == 0))
		else $error("unmapped access answer wrong");
endmodule // adc_out_asserts

bind pipelined_adc_output_control adc_out_asserts #(.WIDTH(WIDTH), .LOCK_CYCLES(LOCK_CYCLES)) chk (.*);

// File: testbench/capture_model.sv
`timescale 1ns/1ps

// ==========================================================
// capture logic at the data pins
module capture_model #(
	parameter int WIDTH = 12
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// converter pins
	input wire logic [WIDTH-1:0] sample_code,
	input wire logic [WIDTH-1:0] data_out,
	input wire logic data_oe,
	input wire logic data_valid,
	// last trusted word and the sample seen with it
	output logic [WIDTH-1:0] word_q,
	output logic [WIDTH-1:0] ramp_q,
	output logic [15:0] words_q
);
	logic [WIDTH-1:0] pin_level;
	// a released bus never shows the last word
	assign pin_level = data_oe ? data_out : ~data_out;
	// latch trusted words only; floating or refilling bus is skipped
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			words_q <= 16'h0000;
		end else if (data_oe && data_valid) begin
			word_q <= pin_level;
			ramp_q <= sample_code;
			words_q <= words_q + 16'h0001;
		end
	end
endmodule // capture_model

// File: testbench/pipelined_adc_output_control_tb.sv
`timescale 1ns/1ps

// ==========================================================
// bench for the converter output block
module pipelined_adc_output_control_tb;
	localparam int WAKE = 20;
	logic clock = 1'b0;
	logic rst_b, psel, penable, pwrite, pready, pslverr, standby_request;
	logic data_oe, data_valid, reference_enable, bias_enable;
	logic duty_cycle_stabilizer, dcs_locked, wake_ready;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [1:0] mode_level;
	logic [11:0] sample_code, data_out, word_q, ramp_q, x;
	logic [15:0] words_q;
	logic e;
	int fails, tests_run;
	pipelined_adc_output_control #(.WAKE_CYCLES(WAKE), .DISCHARGE_RATIO(2)) dut (.*);
	capture_model cap (.*);
	// one free-running 20 MHz source, never gated or divided
	always #25 clock = ~clock;
	// ramp stands in for the core, one code a sample
	always @(posedge clock) sample_code <= sample_code + 12'h001;
	task check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	// one apb transfer; held until pready is seen at an edge
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clock);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
		@(posedge clock);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clock);
			if (pready === 1'b1) break;
		end
		if (i == 20) fails++;
		if (i == 20) test_done;
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task rchk(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		check(n, r & m, x);
	endtask
	// bounded wait for a trusted word; returns cycles waited in w
	task wait_valid(output int w);
		for (w = 0; w < 400; w++) begin
			@(posedge clock);
			if (data_valid === 1'b1) break;
		end
		if (w == 400) fails++;
		if (w == 400) test_done;
	endtask
	task t_regs;
		check("wake after reset", wake_ready, 0);
		rchk("ctrl reset", 8'h00, 32'hFFFF_FFFF, 32'h0);
		apb(1'b0, 8'h0C, 32'h0);
		check("unmapped", {r[30:0], e}, 32'h1);
		apb(1'b1, 8'h00, 32'h18);
		rchk("relock reads 0", 8'h00, 32'h3F, 32'h08);
		apb(1'b1, 8'h00, 32'h0);
	endtask
	// every mode code: format, stabilizer and data timing
	task t_modes;
		logic [1:0] m;
		int w;
		for (int k = 3; k >= 0; k--) begin
			m = k[1:0];
			mode_level <= m;
			tick(8);
			wait_valid(w);
			tick(12);
			x = ramp_q - 12'h008;
			check("word", word_q, {x[11] ^ m[1], x[10:0]});
			check("stabilizer", duty_cycle_stabilizer, m[0] ^ m[1]);
			rchk("status mode", 8'h04, 32'h6, {m[0] ^ m[1], m[1], 1'b0});
		end
	endtask
	task t_standby;
		int w;
		logic [15:0] nw;
		standby_request <= 1'b1;
		tick(6);
		nw = words_q;
		check("oe", {data_oe, data_valid}, 0);
		check("refs", {reference_enable, bias_enable}, 0);
		rchk("status standby", 8'h04, 32'h1, 32'h1);
		tick(40);
		check("no words in standby", words_q, nw);
		standby_request <= 1'b0;
		wait_valid(w);
		// the pipeline refills while the reference recharges, so only the charge bounds it
		check("wake delay", w >= WAKE, 1);
		check("wake delay bound", w <= WAKE + 8, 1);
		tick(2);
		x = ramp_q - 12'h008;
		check("word after wake", word_q, x);
	endtask
	// fill the buffer past full, then drain it to empty
	task t_fifo;
		logic [11:0] p;
		apb(1'b1, 8'h00, 32'h08);
		tick(20);
		rchk("full", 8'h04, 32'hE0, 32'hA0);
		apb(1'b1, 8'h00, 32'h0);
		for (int i = 0; i < 9; i++) begin
			apb(1'b0, 8'h08, 32'h0);
			check("pop valid", r[16], i < 8);
			if (i > 0 && i < 8) check("pop order", r[11:0], p + 12'h001);
			p = r[11:0];
		end
		rchk("empty", 8'h04, 32'hE0, 32'hE0 & 32'h60);
		apb(1'b1, 8'h04, 32'h20);
		rchk("overflow clear", 8'h04, 32'h20, 32'h0);
	endtask
	initial begin
		{rst_b, psel, penable, pwrite, standby_request} = 5'b00000;
		{paddr, pwdata, mode_level, sample_code} = '0;
		fails = 0;
		tests_run = 0;
		tick(2);
		rst_b <= 1'b1;
		tick(1);
		t_regs;
		t_modes;
		t_standby;
		t_fifo;
		test_done;
	end
endmodule // pipelined_adc_output_control_tb
